// ===== pkg/spig_pkg.sv
package spig_pkg;
    // ----------------------------------------------------------------
    // Interrupt controller shape
    // ----------------------------------------------------------------
    localparam int NUM_GROUPS = 64;  // Groups seen by the interrupt controller
    localparam int NUM_LINES  = 32;  // Lines per group
    // Group numbers of the sources
    localparam int GRP_CORE   = 0;
    localparam int GRP_DMA    = 2;
    localparam int GRP_SPI    = 3;   // 3..4
    localparam int GRP_TWI    = 5;
    localparam int GRP_SER    = 6;   // 6..9
    localparam int GRP_SSER   = 10;  // 10..12
    localparam int GRP_GPIO   = 13;  // 13..17
    localparam int GRP_PS2    = 18;
    localparam int GRP_EXT    = 19;
    localparam int GRP_PM     = 20;
    localparam int GRP_RTC    = 21;
    localparam int GRP_TC     = 22;  // 22..23
    localparam int GRP_PWM    = 24;
    localparam int GRP_MISC   = 27;  // 27..32, six single-line sources
    // ----------------------------------------------------------------
    // DMA hardware handshake interface numbers
    // ----------------------------------------------------------------
    localparam int HS_CARD_RX = 0;
    localparam int HS_CARD_TX = 1;
    localparam int HS_BSC_TX  = 2;
    localparam int HS_AC97    = 3;   // A rx, A tx, B rx, B tx on 3..6
    localparam int HS_EXT     = 7;   // External requests 0..3 on 7..10
    localparam int NUM_HS     = 11;
    // ----------------------------------------------------------------
    // Clock ratios and pins
    // ----------------------------------------------------------------
    localparam logic [4:0] DIV4_MASK  = 5'h03;  // bus B / 4
    localparam logic [4:0] DIV8_MASK  = 5'h07;  // bus B / 8, bus A / 8
    localparam logic [4:0] DIV16_MASK = 5'h0F;  // bus B / 16
    localparam logic [4:0] DIV32_MASK = 5'h1F;  // bus B / 32, bus A / 32
    localparam int PB_NMI     = 24;  // Non-maskable input pin
    localparam int PB_EXT     = 25;  // External inputs 0..3 on 25..28
    localparam int NUM_TRACE  = 10;
    // Trace pin map: bit 5 set means port C, low bits the line.
    // Order: start/end 0, start/end 1, clock, event, data 0..5
    localparam logic [5:0] TRACE_MAP0 [NUM_TRACE] =
        '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h09};
    localparam logic [5:0] TRACE_MAP1 [NUM_TRACE] =
        '{6'h20, 6'h21, 6'h22, 6'h1C, 6'h25, 6'h26, 6'h2B, 6'h2C, 6'h2E, 6'h32};
    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic xfer_done;   // Line 4
        logic src_txn;     // Line 3
        logic error;       // Line 2
        logic dst_txn;     // Line 1
        logic block_done;  // Line 0
    } spig_dma_irq_type;
    typedef struct packed {
        logic [5:0] trace_message_data_out;
        logic       debug_event_output_n;
        logic       trace_clock_out;
        logic [1:0] trace_message_start_end;
    } spig_trace_type;
endpackage

// ===== hw/spig_glue.sv
`timescale 1ns/1ps
// Summary of operation
// - Request array of 64 groups, 32 lines.
// - Lines in a group share one request.
// - DMA on group 2; core on group 0.
// - Single-line peripherals on their own group.
// - External, timer and misc sources placed.
// - DMA handshake interfaces numbered zero to ten.
// - Each timer channel picks its own clock.
// - Internal sources: slow oscillator, then divides.
// - Serial ports get bus clock over 8.
// - SPI ports get bus clock over 32.
// - Port B 24..28 feed NMI and external inputs.
// - Enabled trace overrides GPIO pin requests.
// - Map select picks port B set or port C set with event on B 28.
module spig_glue
    import spig_pkg::*;
(
    input  wire logic                                 sys_clk,
    input  wire logic                                 rst_b,
    input  wire logic                                 core_compare_irq,
    input  wire logic                                 perf_overflow_irq,
    input  wire spig_dma_irq_type                     dma_controller_irq,
    input  wire logic [1:0]                           spi_irq,
    input  wire logic                                 twi_irq,
    input  wire logic [3:0]                           serial_irq,
    input  wire logic [2:0]                           sync_serial_irq,
    input  wire logic [4:0]                           gpio_irq,
    input  wire logic                                 ps2_port_irq,
    input  wire logic                                 pm_irq,
    input  wire logic                                 rtc_irq,
    input  wire logic [3:0]                           ext_ctrl_irq,
    input  wire logic [1:0][2:0]                      tc_irq,
    input  wire logic [6:0]                           misc_irq,
    output logic      [NUM_GROUPS-1:0][NUM_LINES-1:0] interrupt_controller_req,
    output logic      [NUM_GROUPS-1:0]                interrupt_controller_group_req,
    input  wire logic [1:0]                           card_dma_req,
    input  wire logic                                 bsc_dma_req,
    input  wire logic [3:0]                           ac97_dma_req,
    input  wire logic [3:0]                           ext_dma_req_pin,
    output logic      [NUM_HS-1:0]                    dma_controller_hs_req,
    input  wire logic                                 slow_oscillator_clock,
    input  wire logic [1:0][2:0]                      tc_external_source,
    input  wire logic [5:0][2:0]                      tc_clock_select,
    output logic      [4:0]                           tc_internal_en,
    output logic      [5:0]                           tc_count_en,
    output logic      [3:0]                           serial_clk_en,
    output logic      [1:0]                           spi_clk_en,
    input  wire logic [31:0]                          pb_pin_in,
    output logic                                      nmi_level,
    output logic      [3:0]                           external_irq_input,
    input  wire logic                                 debug_event_input_pin_n,
    output logic                                      debug_event_input_n,
    input  wire logic                                 trace_enable,
    input  wire logic                                 trace_pin_map_select,
    input  wire spig_trace_type                       trace_sig,
    input  wire logic [31:0]                          pb_gpio_out,
    input  wire logic [31:0]                          pb_gpio_oe,
    input  wire logic [31:0]                          pc_gpio_out,
    input  wire logic [31:0]                          pc_gpio_oe,
    output logic      [31:0]                          pb_pin_out,
    output logic      [31:0]                          pb_pin_oe,
    output logic      [31:0]                          pc_pin_out,
    output logic      [31:0]                          pc_pin_oe
);
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Divider tap: true on the last count of a power-of-two period
    function automatic logic div_hit(input logic [4:0] cnt, input logic [4:0] mask);
        div_hit = ((cnt & mask) == mask);
    endfunction
    // Rising edge of a filtered level
    function automatic logic rise(input logic prev, input logic cur);
        rise = cur & ~prev;
    endfunction

    localparam int NSYNC = 43;                   // 32 port B, 4 DMA, osc, 6 ext clocks
    logic [NSYNC-1:0] sync1_reg;                 // First stage, read only by stage two
    logic [NSYNC-1:0] sync2_reg;                 // Second stage
    logic [NSYNC-1:0] sync3_reg;                 // Third stage
    logic [NSYNC-1:0] level_reg;                 // Filtered levels
    logic [NSYNC-1:0] level_old_reg;             // Previous filtered levels
    logic [NSYNC-1:0] sync_in;                   // Raw pin bundle
    logic [4:0]       div_cnt_reg;               // Shared bus clock divider
    logic [1:0][7:0]  tc_src;                    // Eight sources per timer block
    logic             dbg_s1_reg;                // Event input first stage
    logic             dbg_s2_reg;
    logic             dbg_s3_reg;

    assign sync_in = {tc_external_source, slow_oscillator_clock, ext_dma_req_pin, pb_pin_in};

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // Three stages; a level is accepted only when stages two and three
    // agree, so a single-cycle glitch on a pin never reaches the logic
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            sync1_reg     <= '0;
            sync2_reg     <= '0;
            sync3_reg     <= '0;
            level_reg     <= '0;
            level_old_reg <= '0;
        end
        else
        begin
            sync1_reg     <= sync_in;
            sync2_reg     <= sync1_reg;
            sync3_reg     <= sync2_reg;
            for (int i = 0; i < NSYNC; i++)
            begin
                if (sync2_reg[i] == sync3_reg[i])
                    level_reg[i] <= sync3_reg[i];
            end
            level_old_reg <= level_reg;
        end
    end

    // Pin-driven levels for the external interrupt controller
    assign nmi_level          = level_reg[PB_NMI];
    assign external_irq_input = level_reg[PB_EXT+3:PB_EXT];

    // Event input sits on its own pin in both trace maps
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            dbg_s1_reg          <= 1'b1;
            dbg_s2_reg          <= 1'b1;
            dbg_s3_reg          <= 1'b1;
            debug_event_input_n <= 1'b1;
        end
        else
        begin
            dbg_s1_reg <= debug_event_input_pin_n;
            dbg_s2_reg <= dbg_s1_reg;
            dbg_s3_reg <= dbg_s2_reg;
            if (dbg_s2_reg == dbg_s3_reg)
                debug_event_input_n <= dbg_s3_reg;
        end
    end

    // ----------------------------------------------------------------
    // Clock enables
    // ----------------------------------------------------------------
    // Both peripheral buses run on sys_clk here, so one counter serves
    // all ratios and keeps every derived enable phase-aligned
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            div_cnt_reg    <= '0;
            tc_internal_en <= '0;
            serial_clk_en  <= '0;
            spi_clk_en     <= '0;
        end
        else
        begin
            div_cnt_reg       <= div_cnt_reg + 5'h01;
            // Slow oscillator edge first, then the four divides
            tc_internal_en[0] <= rise(level_old_reg[36], level_reg[36]);
            tc_internal_en[1] <= div_hit(div_cnt_reg, DIV4_MASK);
            tc_internal_en[2] <= div_hit(div_cnt_reg, DIV8_MASK);
            tc_internal_en[3] <= div_hit(div_cnt_reg, DIV16_MASK);
            tc_internal_en[4] <= div_hit(div_cnt_reg, DIV32_MASK);
            serial_clk_en     <= {4{div_hit(div_cnt_reg, DIV8_MASK)}};
            spi_clk_en        <= {2{div_hit(div_cnt_reg, DIV32_MASK)}};
        end
    end

    // Per-block source list: five internal, then three external edges
    always_comb
    begin
        for (int b = 0; b < 2; b++)
        begin
            tc_src[b][4:0] = tc_internal_en;
            for (int x = 0; x < 3; x++)
                tc_src[b][5+x] = rise(level_old_reg[37+3*b+x], level_reg[37+3*b+x]);
        end
    end

    // Each channel picks its own source; select codes 5..7 are external
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            tc_count_en <= '0;
        else
        begin
            for (int c = 0; c < 6; c++)
                tc_count_en[c] <= tc_src[c/3][tc_clock_select[c]];
        end
    end

    // ----------------------------------------------------------------
    // Interrupt request map
    // ----------------------------------------------------------------
    // Everything starts at zero so unconnected groups stay silent
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            interrupt_controller_req <= '0;
        else
        begin
            interrupt_controller_req <= '0;
            interrupt_controller_req[GRP_CORE][0]   <= core_compare_irq;
            interrupt_controller_req[GRP_CORE][1]   <= perf_overflow_irq;
            interrupt_controller_req[GRP_DMA][4:0]  <= dma_controller_irq;
            interrupt_controller_req[GRP_TWI][0]    <= twi_irq;
            interrupt_controller_req[GRP_PS2][0]    <= ps2_port_irq;
            interrupt_controller_req[GRP_PM][0]     <= pm_irq;
            interrupt_controller_req[GRP_RTC][0]    <= rtc_irq;
            interrupt_controller_req[GRP_EXT][3:0]  <= ext_ctrl_irq;
            interrupt_controller_req[GRP_PWM][0]    <= misc_irq[0];
            for (int i = 0; i < 2; i++)
            begin
                interrupt_controller_req[GRP_SPI+i][0] <= spi_irq[i];
                interrupt_controller_req[GRP_TC+i][2:0] <= tc_irq[i];
            end
            for (int i = 0; i < 4; i++)
                interrupt_controller_req[GRP_SER+i][0] <= serial_irq[i];
            for (int i = 0; i < 3; i++)
                interrupt_controller_req[GRP_SSER+i][0] <= sync_serial_irq[i];
            for (int i = 0; i < 5; i++)
                interrupt_controller_req[GRP_GPIO+i][0] <= gpio_irq[i];
            for (int i = 1; i < 7; i++)
                interrupt_controller_req[GRP_MISC+i-1][0] <= misc_irq[i];
        end
    end

    // One request per group: lines carry no priority of their own
    always_comb
    begin
        for (int g = 0; g < NUM_GROUPS; g++)
            interrupt_controller_group_req[g] = |interrupt_controller_req[g];
    end

    // ----------------------------------------------------------------
    // DMA handshake map
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            dma_controller_hs_req <= '0;
        else
        begin
            dma_controller_hs_req[HS_CARD_RX]          <= card_dma_req[0];
            dma_controller_hs_req[HS_CARD_TX]          <= card_dma_req[1];
            dma_controller_hs_req[HS_BSC_TX]           <= bsc_dma_req;
            dma_controller_hs_req[HS_AC97+3:HS_AC97]   <= ac97_dma_req;
            dma_controller_hs_req[HS_EXT+3:HS_EXT]     <= level_reg[35:32];
        end
    end

    // ----------------------------------------------------------------
    // Trace pin override
    // ----------------------------------------------------------------
    // Trace wins over GPIO regardless of its configuration; the pin is
    // always driven while owned, so a GPIO input there reads trace data
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            pb_pin_out <= '0;
            pb_pin_oe  <= '0;
            pc_pin_out <= '0;
            pc_pin_oe  <= '0;
        end
        else
        begin
            automatic logic [31:0] b_o = pb_gpio_out;
            automatic logic [31:0] b_e = pb_gpio_oe;
            automatic logic [31:0] c_o = pc_gpio_out;
            automatic logic [31:0] c_e = pc_gpio_oe;
            automatic logic [NUM_TRACE-1:0] tv = trace_sig;
            automatic logic [5:0] m;
            if (trace_enable)
            begin
                for (int i = 0; i < NUM_TRACE; i++)
                begin
                    m = trace_pin_map_select ? TRACE_MAP1[i] : TRACE_MAP0[i];
                    if (m[5])
                    begin
                        c_o[m[4:0]] = tv[i];
                        c_e[m[4:0]] = 1'b1;
                    end
                    else
                    begin
                        b_o[m[4:0]] = tv[i];
                        b_e[m[4:0]] = 1'b1;
                    end
                end
            end
            pb_pin_out <= b_o;
            pb_pin_oe  <= b_e;
            pc_pin_out <= c_o;
            pc_pin_oe  <= c_e;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence s_pin_high;
        pb_pin_in[PB_EXT] [*4];
    endsequence
    sequence s_serial_gap;
        !serial_clk_en[0] [*7] ##1 serial_clk_en[0];
    endsequence

    AST_SHAPE: assert property (!interrupt_controller_req[GRP_CORE][NUM_LINES-1]
        && !interrupt_controller_req[NUM_GROUPS-1][NUM_LINES-1])
        else $error("request array corner raised");
    AST_GROUP_OR: assert property (interrupt_controller_group_req[GRP_TC]
        == |interrupt_controller_req[GRP_TC][2:0]) else $error("group request mismatch");
    AST_DMA_MAP: assert property ($past(rst_b) |->
        interrupt_controller_req[GRP_DMA][4:0] == $past(dma_controller_irq))
        else $error("dma interrupt lines misplaced");
    AST_SPI1_MAP: assert property ($past(rst_b) |->
        interrupt_controller_req[GRP_SPI+1][0] == $past(spi_irq[1]))
        else $error("second spi interrupt misplaced");
    AST_EBI_MAP: assert property ($past(rst_b) |->
        interrupt_controller_req[GRP_MISC+5][0] == $past(misc_irq[6]))
        else $error("last misc interrupt misplaced");
    AST_HS_BSC: assert property ($past(rst_b) |->
        dma_controller_hs_req[HS_BSC_TX] == $past(bsc_dma_req))
        else $error("handshake two misplaced");
    AST_TC_SEL: assert property ($past(rst_b) && $past(tc_clock_select[2]) == 3'h3 |->
        tc_count_en[2] == $past(tc_internal_en[3])) else $error("timer select wrong");
    AST_TC_NEST: assert property (tc_internal_en[4] |-> &tc_internal_en[3:1])
        else $error("divide taps out of phase");
    AST_SERIAL_DIV: assert property (serial_clk_en[0] |=> s_serial_gap)
        else $error("serial enable period not eight");
    AST_SPI_DIV: assert property (spi_clk_en[0] |-> serial_clk_en[0] ##32 spi_clk_en[0])
        else $error("spi enable period not thirty-two");
    AST_EXT_PIN: assert property (s_pin_high |=> external_irq_input[0])
        else $error("external input not followed");
    AST_TRACE_B: assert property ($past(rst_b) && $past(trace_enable)
        && !$past(trace_pin_map_select) |-> pb_pin_out[9:4]
        == $past(trace_sig.trace_message_data_out) && &pb_pin_oe[9:0])
        else $error("trace did not own port b");
    AST_TRACE_C: assert property ($past(rst_b) && $past(trace_enable)
        && $past(trace_pin_map_select) |-> pb_pin_out[28]
        == $past(trace_sig.debug_event_output_n) && pc_pin_oe[0])
        else $error("alternate trace map wrong");
    AST_UNUSED: assert property (interrupt_controller_req[1] == '0
        && interrupt_controller_req[25] == '0 && interrupt_controller_req[63:33] == '0)
        else $error("unused group raised");
endmodule // spig_glue

// ===== bench/spig_interrupt_controller_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Interrupt controller stand-in
// ----------------------------------------------------------------
module spig_interrupt_controller_model
    import spig_pkg::*;
(
    input  wire logic [NUM_GROUPS-1:0] group_req,  // One request per group
    output logic      [6:0]            pend_grp,   // Winning group number
    output logic                       pend_any    // Any group pending
);
    // Lowest group wins; lines inside a group are never ranked
    always_comb
    begin
        pend_grp = 7'h00;
        pend_any = 1'b0;
        for (int g = NUM_GROUPS - 1; g >= 0; g--)
            if (group_req[g])
            begin
                pend_grp = 7'(g);
                pend_any = 1'b1;
            end
    end
endmodule // spig_interrupt_controller_model

// ===== bench/spig_glue_tb.sv
`timescale 1ns/1ps
module spig_glue_tb;
    import spig_pkg::*;
    // ----------------------------------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------------------------------
    logic sys_clk = 0, rst_b = 0, osc = 0, ten = 0, tsel = 0, evt_n = 1;
    logic [41:0]      src = '0;     // All interrupt sources, table order
    logic [10:0]      hsrc = '0;    // Handshake sources, interface order
    logic [1:0][2:0]  xsrc = '0;    // External timer clocks, block 1 source 0 runs
    logic [5:0][2:0]  tsl = {3'h0, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1};
    logic [31:0]      pbin = '0, pbo = 32'hA5A55A5A, pboe = 32'h0F0F0F0F;
    logic [31:0]      pco = 32'h3C3CC3C3, pcoe = 32'hFF00FF00;
    logic [9:0]       tr = 10'h2A5;  // Trace bits in struct order
    logic [63:0][31:0] req;
    logic [63:0]      greq;
    logic [10:0]      hs;
    logic [4:0]       tie;
    logic [5:0]       tce;
    logic [3:0]       sce, ext;
    logic [1:0]       spe;
    logic [6:0]       pg;
    logic             nmi, evo_n, pany;
    logic [31:0]      pbpo, pbpoe, pcpo, pcpoe;
    int err_count = 0, checks_done = 0;
    // Group of each source bit; lines follow from position
    int grp[42] = '{0, 0, 2, 2, 2, 2, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 16,
                    17, 18, 20, 21, 19, 19, 19, 19, 22, 22, 22, 23, 23, 23, 24, 27, 28,
                    29, 30, 31, 32};
    int m1[10] = '{32, 33, 34, 28, 37, 38, 43, 44, 46, 50};  // Alternate map, 32+ is port C
    spig_glue uut (.sys_clk(sys_clk), .rst_b(rst_b), .core_compare_irq(src[0]),
        .perf_overflow_irq(src[1]), .dma_controller_irq(src[6:2]), .spi_irq(src[8:7]),
        .twi_irq(src[9]), .serial_irq(src[13:10]), .sync_serial_irq(src[16:14]),
        .gpio_irq(src[21:17]), .ps2_port_irq(src[22]), .pm_irq(src[23]), .rtc_irq(src[24]),
        .ext_ctrl_irq(src[28:25]), .tc_irq(src[34:29]), .misc_irq(src[41:35]),
        .interrupt_controller_req(req), .interrupt_controller_group_req(greq),
        .card_dma_req(hsrc[1:0]), .bsc_dma_req(hsrc[2]), .ac97_dma_req(hsrc[6:3]),
        .ext_dma_req_pin(hsrc[10:7]), .dma_controller_hs_req(hs), .slow_oscillator_clock(osc),
        .tc_external_source(xsrc), .tc_clock_select(tsl), .tc_internal_en(tie),
        .tc_count_en(tce), .serial_clk_en(sce), .spi_clk_en(spe), .pb_pin_in(pbin),
        .nmi_level(nmi), .external_irq_input(ext), .debug_event_input_pin_n(evt_n),
        .debug_event_input_n(evo_n), .trace_enable(ten), .trace_pin_map_select(tsel),
        .trace_sig(tr), .pb_gpio_out(pbo), .pb_gpio_oe(pboe), .pc_gpio_out(pco),
        .pc_gpio_oe(pcoe), .pb_pin_out(pbpo), .pb_pin_oe(pbpoe), .pc_pin_out(pcpo),
        .pc_pin_oe(pcpoe));
    spig_interrupt_controller_model far (.group_req(greq), .pend_grp(pg), .pend_any(pany));
    // ----------------------------------------------------------------
    // Clocks, helpers and verdict
    // ----------------------------------------------------------------
    initial forever #50 sys_clk = ~sys_clk;
    always #1000 osc = ~osc;  // Slow clock, far below sys_clk / 4
    // External timer clock: period of 32 cycles, edges on falling sys_clk
    always #1600 xsrc[1][0] = ~xsrc[1][0];
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic chk(input string nm, input logic [2047:0] e, input logic [2047:0] g);
        checks_done++;
        if (e !== g)
        begin
            err_count++;
            $display("BAD %s exp %0h got %0h", nm, e, g);
        end
    endtask
    task automatic stop_test;
        if (err_count == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_irq;  // Walk one source at a time over the whole map
        logic [63:0][31:0] e;
        int ln;
        for (int i = 0; i < 42; i++)
        begin
            ln = i < 2 ? i : i < 7 ? i - 2 : (i > 24 && i < 29) ? i - 25 :
                 (i > 28 && i < 35) ? (i - 29) % 3 : 0;
            src = 42'h1 << i;
            cyc(2);
            e = '0;
            e[grp[i]][ln] = 1'b1;
            chk("req", e, req);
            chk("group", 64'h1 << grp[i], greq);
            chk("pend", {1'b1, 7'(grp[i])}, {pany, pg});
        end
        src = '0;
        cyc(2);
        chk("idle", '0, greq);
    endtask
    task automatic t_dma;  // Pins need the filter delay, a single-cycle glitch is dropped
        for (int i = 0; i < 11; i++)
        begin
            hsrc = 11'h1 << i;
            cyc(i < 7 ? 2 : 8);
            chk("hs", 11'h1 << i, hs);
        end
        hsrc = 11'h080;
        cyc(1);
        hsrc = '0;
        cyc(8);
        chk("hs_glitch", '0, hs);
    endtask
    task automatic t_clk;  // Count enables over 256 cycles, whole periods of each divide and the external clock
        int n[13] = '{default: 0};
        repeat (256)
        begin
            @(posedge sys_clk);
            #1;
            for (int k = 0; k < 5; k++) n[k] += tie[k];
            for (int k = 0; k < 6; k++) n[5 + k] += tce[k];
            n[11] += $countones(sce);
            n[12] += spe[0] + spe[1];
        end
        cyc(1);
        chk("osc", n[0] >= 12 && n[0] <= 13, 1);
        for (int k = 1; k < 5; k++) chk("tc_div", 256 >> (k + 1), n[k]);
        for (int k = 0; k < 4; k++) chk("tc_ch", 256 >> (k + 2), n[5 + k]);
        chk("tc_ext", 8, n[9]);
        chk("tc_osc", n[10] >= 12 && n[10] <= 13, 1);
        chk("serial", 128, n[11]);
        chk("spi", 16, n[12]);
    endtask
    task automatic t_pins;  // Port B 24..28 to the interrupt inputs, then a glitch
        pbin[28:24] = 5'h15;
        cyc(8);
        chk("nmi", 1, nmi);
        chk("ext", 4'hA, ext);
        pbin[28:24] = 5'h0A;
        cyc(8);
        chk("ext", 4'h5, ext);
        pbin[25] = 1'b0;
        cyc(1);
        pbin[25] = 1'b1;
        evt_n = 1'b0;
        cyc(8);
        chk("ext_glitch", 4'h5, ext);
        chk("event_in", 0, evo_n);
    endtask
    task automatic t_trace;  // Both maps override GPIO, then plain passthrough
        logic [31:0] eb, ebe, ec, ece;
        int p;
        for (int s = 0; s < 2; s++)
        begin
            ten = 1'b1;
            tsel = 1'(s);
            cyc(2);
            {eb, ebe, ec, ece} = {pbo, pboe, pco, pcoe};
            for (int k = 0; k < 10; k++)
            begin
                p = s ? m1[k] : k;
                if (p < 32) {eb[p], ebe[p]} = {tr[k], 1'b1};
                else {ec[p - 32], ece[p - 32]} = {tr[k], 1'b1};
            end
            chk("pins", {eb, ebe, ec, ece}, {pbpo, pbpoe, pcpo, pcpoe});
        end
        ten = 1'b0;
        cyc(2);
        chk("gpio", {pbo, pboe, pco, pcoe}, {pbpo, pbpoe, pcpo, pcpoe});
    endtask
    // ----------------------------------------------------------------
    // Main sequence and hang guard
    // ----------------------------------------------------------------
    initial
    begin
        cyc(8);
        rst_b = 1'b1;
        cyc(4);
        t_irq();
        t_dma();
        t_clk();
        t_pins();
        t_trace();
        stop_test();
    end
    initial
    begin
        #1000000;
        err_count++;
        stop_test();
    end
endmodule // spig_glue_tb
